/* File: dv/pfd_fault_delay_tb.sv */
// Self-checking bench for the fault delay block
`include "pfd_regs.svh"
`default_nettype none
module pfd_fault_delay_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pfd_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    pfd_byte_t reg_addr = 8'h00;
    pfd_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [2:0] comp = 3'h0;
    logic [2:0] dis = 3'h0;
    logic [1:0] wd_cnt = 2'h0;
    logic wd_run = 1'b1;
    logic wd_q = 1'b0;
    logic mode_sel = 1'b0;
    logic supply_ok = 1'b0;
    logic host_run = 1'b0;
    logic host_charge_off = 1'b0;
    wire pfd_byte_t reg_rdata;
    wire logic charge_cmd, discharge_cmd, zv_off_bit, charge_drv, discharge_drv, zv_drv;
    wire pfd_code_t charge_level, discharge_level;
    wire logic [2:0] trip;
    int ticks = 0;
    int cyc = 0;
    int n_mismatch = 0;
    int n_checks = 0;

    pfd_fault_delay i_pfd_fault_delay (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .watchdog_clock_input(wd_cnt[1]),
        .overload_comp(comp[0]), .charge_short_comp(comp[1]), .discharge_short_comp(comp[2]),
        .overload_sense_disable(dis[0]), .charge_short_sense_disable(dis[1]),
        .discharge_short_sense_disable(dis[2]), .power_mode_select_input(mode_sel), .supply_ok(supply_ok),
        .charge_fet_bit(charge_cmd), .discharge_fet_bit(discharge_cmd), .zero_volt_fet_off_bit(zv_off_bit),
        .charge_fet_drive(charge_drv), .discharge_fet_drive(discharge_drv), .zero_volt_fet_drive(zv_drv),
        .charge_short_level_code(charge_level), .discharge_short_level_code(discharge_level),
        .overload_trip(trip[0]), .charge_short_trip(trip[1]), .discharge_short_trip(trip[2]));
    pfd_host_model i_pfd_host_model (
        .clk(clk), .reset_n(reset_n), .power_mode_select_input(mode_sel), .supply_ok(supply_ok),
        .host_run(host_run), .host_charge_off(host_charge_off), .charge_fet_bit(charge_cmd),
        .discharge_fet_bit(discharge_cmd), .zero_volt_fet_off_bit(zv_off_bit));

    always #12.5 clk = ~clk;
    // Fast watchdog clock, four system clocks per tick
    always @(negedge clk) if (wd_run) wd_cnt <= wd_cnt + 2'h1;
    always @(posedge clk) begin
        wd_q <= wd_cnt[1];
        if (wd_cnt[1] && !wd_q) ticks <= ticks + 1;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_write(input pfd_byte_t a, input pfd_byte_t d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic reg_read(input pfd_byte_t a, output pfd_byte_t d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic sync_tick();
        @(posedge clk);
        while (wd_cnt !== 2'h2) @(posedge clk);
        @(negedge clk);
    endtask
    // Holds one fault until its trip, checks tick count, FET drives and clearing
    task automatic run_fault(input pfd_chan_t ch, input int limit);
        int n;
        int t0;
        sync_tick();
        comp[ch] = 1'b1;
        t0 = ticks;
        n = 0;
        while (trip[ch] !== 1'b1 && n < 6000) begin
            @(negedge clk);
            n++;
        end
        check(12'(ticks - t0), 12'(limit + 1));
        repeat (2) @(negedge clk);
        check({9'h0, charge_drv, discharge_drv, zv_drv}, 12'h0);
        comp[ch] = 1'b0;
        host_run = 1'b0;
        repeat (3) @(negedge clk);
        check({11'h0, trip[ch]}, 12'h0);
        host_run = 1'b1;
        repeat (3) @(negedge clk);
        check({10'h0, charge_drv, discharge_drv}, 12'h3);
    endtask
    task automatic t_power_up();
        check({9'h0, charge_drv, discharge_drv, zv_drv}, 12'h1);
        mode_sel = 1'b1;
        repeat (3) @(negedge clk);
        check({9'h0, charge_drv, discharge_drv, zv_drv}, 12'h4);
        supply_ok = 1'b1;
        host_run = 1'b1;
        host_charge_off = 1'b1;
        repeat (3) @(negedge clk);
        check({9'h0, charge_drv, discharge_drv, zv_drv}, 12'h2);
        host_charge_off = 1'b0;
        mode_sel = 1'b0;
        repeat (3) @(negedge clk);
        check({9'h0, charge_drv, discharge_drv, zv_drv}, 12'h6);
        host_run = 1'b0;
        repeat (3) @(negedge clk);
        check({9'h0, charge_drv, discharge_drv, zv_drv}, 12'h1);
        host_run = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    task automatic t_regs();
        pfd_byte_t d;
        pfd_byte_t addrs [3] = '{`PFD_ADDR_OVERLOAD_DELAY, `PFD_ADDR_CHARGE_SHORT, `PFD_ADDR_DISCHARGE_SHORT};
        pfd_byte_t after_ff [3] = '{8'h0f, 8'hff, 8'hff};
        foreach (addrs[i]) begin
            reg_read(addrs[i], d);
            check(12'(d), 12'h0);
            reg_write(addrs[i], 8'hff);
            reg_read(addrs[i], d);
            check(12'(d), 12'(after_ff[i]));
        end
        reg_write(8'h09, 8'ha5);
        reg_read(8'h09, d);
        check(12'(d), 12'(`PFD_RDATA_UNMAPPED));
        reg_read(`PFD_ADDR_CHARGE_SHORT, d);
        check(12'(d), 12'hff);
        for (int c = 0; c < 16; c++) begin
            reg_write(`PFD_ADDR_CHARGE_SHORT, {4'h0, 4'(c)});
            reg_write(`PFD_ADDR_DISCHARGE_SHORT, {4'h0, ~4'(c)});
            check(12'(charge_level), 12'(c));
            check(12'(discharge_level), 12'(4'hf - 4'(c)));
        end
    endtask
    task automatic t_delays();
        int codes [3] = '{0, 1, 15};
        foreach (codes[i]) begin
            reg_write(`PFD_ADDR_CHARGE_SHORT, {4'(codes[i]), 4'h0});
            run_fault(PFD_CH_CHARGE_SHORT, `PFD_SC_STEP_TICKS * codes[i]);
            reg_write(`PFD_ADDR_DISCHARGE_SHORT, {4'(codes[i]), 4'h0});
            run_fault(PFD_CH_DISCHARGE_SHORT, `PFD_SC_STEP_TICKS * codes[i]);
        end
        reg_write(`PFD_ADDR_OVERLOAD_DELAY, 8'h00);
        run_fault(PFD_CH_OL, `PFD_OL_BASE_TICKS);
        reg_write(`PFD_ADDR_OVERLOAD_DELAY, 8'h0f);
        run_fault(PFD_CH_OL, `PFD_OL_BASE_TICKS + 15 * `PFD_OL_STEP_TICKS);
    endtask
    task automatic t_restart_disable_stop();
        reg_write(`PFD_ADDR_DISCHARGE_SHORT, 8'h20);
        sync_tick();
        comp[PFD_CH_DISCHARGE_SHORT] = 1'b1;
        repeat (12) @(negedge clk);
        comp[PFD_CH_DISCHARGE_SHORT] = 1'b0;
        repeat (8) @(negedge clk);
        run_fault(PFD_CH_DISCHARGE_SHORT, 2 * `PFD_SC_STEP_TICKS);
        reg_write(`PFD_ADDR_OVERLOAD_DELAY, 8'h00);
        reg_write(`PFD_ADDR_CHARGE_SHORT, 8'h00);
        reg_write(`PFD_ADDR_DISCHARGE_SHORT, 8'h00);
        dis = 3'h7;
        comp = 3'h7;
        repeat (160) @(negedge clk);
        check({9'h0, trip}, 12'h0);
        comp = 3'h0;
        dis = 3'h0;
        run_fault(PFD_CH_CHARGE_SHORT, 0);
        sync_tick();
        wd_run = 1'b0;
        comp[PFD_CH_DISCHARGE_SHORT] = 1'b1;
        repeat (200) @(negedge clk);
        check({11'h0, trip[PFD_CH_DISCHARGE_SHORT]}, 12'h0);
        comp[PFD_CH_DISCHARGE_SHORT] = 1'b0;
        wd_run = 1'b1;
        run_fault(PFD_CH_DISCHARGE_SHORT, 0);
    endtask

    initial begin
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        t_power_up();
        t_regs();
        t_delays();
        t_restart_disable_stop();
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* File: dv/pfd_host_model.sv */
// Host controller model that drives the FET command bits
`default_nettype none
module pfd_host_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic power_mode_select_input,
    input wire logic supply_ok,
    input wire logic host_run,
    input wire logic host_charge_off,
    output logic charge_fet_bit,
    output logic discharge_fet_bit,
    output logic zero_volt_fet_off_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    // Commands change just after the falling edge
    always @(negedge clk or negedge reset_n) begin
        if (!reset_n || !(host_run && supply_ok)) begin
            charge_fet_bit <= 1'b0;
            discharge_fet_bit <= 1'b0;
            zero_volt_fet_off_bit <= 1'b0;
        end else if (!power_mode_select_input) begin
            charge_fet_bit <= !host_charge_off;
            discharge_fet_bit <= 1'b1;
            zero_volt_fet_off_bit <= 1'b1;
        end else begin
            charge_fet_bit <= !host_charge_off;
            discharge_fet_bit <= 1'b1;
            zero_volt_fet_off_bit <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/pfd_delay_timer.sv */
// Blanking delay counter for one current fault channel
`default_nettype none
module pfd_delay_timer (
    input wire logic clk,
    input wire logic reset_n,
    pfd_timer_if.timer bus
);
    import pfd_pkg::*;

    pfd_ticks_t count;
    pfd_ticks_t next_count;
    logic next_trip;
    logic trip_set;

    always_comb begin
        next_count = count;
        next_trip = bus.trip;
        trip_set = bus.fault && bus.tick && (count >= bus.limit);
        if (!bus.fault) begin
            next_count = '0;
        end else if (bus.tick && !trip_set) begin
            next_count = pfd_ticks_t'(count + 1'b1);
        end
        if (trip_set) begin
            next_trip = 1'b1;
        end else if (bus.clear) begin
            next_trip = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
            bus.trip <= 1'b0;
        end else begin
            count <= next_count;
            bus.trip <= next_trip;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_RESTART: assert property (!bus.fault |=> count == '0)
        else $error("delay count not restarted after fault dropout");
    AST_ZERO_DELAY: assert property (bus.fault && bus.tick && bus.limit == '0 |=> bus.trip)
        else $error("zero delay code did not trip on first sample");
    AST_TICK_ONLY: assert property ($changed(count) && count != '0 |-> $past(bus.tick))
        else $error("delay count advanced without a watchdog tick");
    AST_TRIP_CAUSE: assert property ($rose(bus.trip) |-> $past(count) >= $past(bus.limit))
        else $error("trip before programmed delay elapsed");
endmodule
`default_nettype wire

/* File: hdl/pfd_fault_delay.sv */
// Fault delay configuration registers and FET trip logic
//
// Contract
// - Overload delay register: code in low nibble, upper nibble zero, resets zero.
// - Overload delay is one millisecond plus two milliseconds per code step.
// - Charge short register: level code low nibble, delay code high nibble, reset zero.
// - Charge short level code sets trip level 0.100 V plus 25 mV steps.
// - Charge short delay is code times about 61 microseconds, zero to 915.
// - Charge short fault past its delay turns off all three FET drives.
// - Discharge short register: level code low nibble, delay code high nibble, reset zero.
// - Discharge short level code sets trip level 0.10 V plus 25 mV steps.
// - Discharge short delay is code times about 61 microseconds, zero to 915.
// - Discharge short fault past its delay turns off all three FET drives.
// - Zero-volt mode powers up with charge drive off, zero-volt drive on.
// - Before supply is valid, common mode forces charge drive on once power mode select rises.
// - With supply valid, charge drive follows the charge control bit.
// - Delay timers count watchdog clock rising edges and stop with that clock.
// - Each sense disable bit at one suppresses its fault detection.
// - With supply valid in zero-volt mode, zero-volt off bit at zero keeps that drive on, one turns off.
`include "pfd_regs.svh"
`default_nettype none
module pfd_fault_delay (
    input wire logic clk,
    input wire logic reset_n,
    input wire pfd_pkg::pfd_byte_t reg_addr,
    input wire pfd_pkg::pfd_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output pfd_pkg::pfd_byte_t reg_rdata,
    input wire logic watchdog_clock_input,
    input wire logic overload_comp,
    input wire logic charge_short_comp,
    input wire logic discharge_short_comp,
    input wire logic overload_sense_disable,
    input wire logic charge_short_sense_disable,
    input wire logic discharge_short_sense_disable,
    input wire logic power_mode_select_input,
    input wire logic supply_ok,
    input wire logic charge_fet_bit,
    input wire logic discharge_fet_bit,
    input wire logic zero_volt_fet_off_bit,
    output logic charge_fet_drive,
    output logic discharge_fet_drive,
    output logic zero_volt_fet_drive,
    output pfd_pkg::pfd_code_t charge_short_level_code,
    output pfd_pkg::pfd_code_t discharge_short_level_code,
    output logic overload_trip,
    output logic charge_short_trip,
    output logic discharge_short_trip
);
    import pfd_pkg::*;

    pfd_byte_t overload_delay;
    pfd_byte_t charge_short_config;
    pfd_byte_t discharge_short_config;
    pfd_byte_t next_overload_delay;
    pfd_byte_t next_charge_short_config;
    pfd_byte_t next_discharge_short_config;
    pfd_byte_t next_reg_rdata;

    pfd_code_t overload_delay_code;
    pfd_code_t charge_short_delay_code;
    pfd_code_t discharge_short_delay_code;

    logic wd_prev;
    logic wd_tick;

    logic [2:0] comp_vec;
    logic [2:0] disable_vec;
    logic [2:0] trip_vec;
    pfd_ticks_t limit_vec [3];
    logic any_trip;
    logic trip_clear;

    logic next_charge_fet_drive;
    logic next_discharge_fet_drive;
    logic next_zero_volt_fet_drive;

    // Register file: write decode and read mux
    always_comb begin
        next_overload_delay = overload_delay;
        next_charge_short_config = charge_short_config;
        next_discharge_short_config = discharge_short_config;
        next_reg_rdata = reg_rdata;
        if (reg_wr) begin
            case (reg_addr)
                `PFD_ADDR_OVERLOAD_DELAY: next_overload_delay = reg_wdata & `PFD_OL_WRITE_MASK;
                `PFD_ADDR_CHARGE_SHORT: next_charge_short_config = reg_wdata;
                `PFD_ADDR_DISCHARGE_SHORT: next_discharge_short_config = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `PFD_ADDR_OVERLOAD_DELAY: next_reg_rdata = overload_delay;
                `PFD_ADDR_CHARGE_SHORT: next_reg_rdata = charge_short_config;
                `PFD_ADDR_DISCHARGE_SHORT: next_reg_rdata = discharge_short_config;
                default: next_reg_rdata = `PFD_RDATA_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overload_delay <= `PFD_RST_OVERLOAD_DELAY;
            charge_short_config <= `PFD_RST_CHARGE_SHORT;
            discharge_short_config <= `PFD_RST_DISCHARGE_SHORT;
            reg_rdata <= `PFD_RDATA_UNMAPPED;
        end else begin
            overload_delay <= next_overload_delay;
            charge_short_config <= next_charge_short_config;
            discharge_short_config <= next_discharge_short_config;
            reg_rdata <= next_reg_rdata;
        end
    end

    assign charge_short_level_code = charge_short_config[`PFD_LEVEL_MSB:`PFD_LEVEL_LSB];
    assign discharge_short_level_code = discharge_short_config[`PFD_LEVEL_MSB:`PFD_LEVEL_LSB];

    assign overload_delay_code = overload_delay[`PFD_LEVEL_MSB:`PFD_LEVEL_LSB];
    assign charge_short_delay_code = charge_short_config[`PFD_DELAY_MSB:`PFD_DELAY_LSB];
    assign discharge_short_delay_code = discharge_short_config[`PFD_DELAY_MSB:`PFD_DELAY_LSB];

    // Watchdog edge sampling
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // High so a clock already high at release is no false tick
            wd_prev <= 1'b1;
        end else begin
            wd_prev <= watchdog_clock_input;
        end
    end

    // timers advance on watchdog rising edge
    assign wd_tick = watchdog_clock_input && !wd_prev;

    // Delay limits in watchdog ticks
    always_comb begin
        limit_vec[PFD_CH_OL] = pfd_ticks_t'(`PFD_OL_BASE_TICKS + `PFD_OL_STEP_TICKS * overload_delay_code);
        limit_vec[PFD_CH_CHARGE_SHORT] = pfd_ticks_t'(`PFD_SC_STEP_TICKS * charge_short_delay_code);
        limit_vec[PFD_CH_DISCHARGE_SHORT] = pfd_ticks_t'(`PFD_SC_STEP_TICKS * discharge_short_delay_code);
    end

    assign comp_vec = {discharge_short_comp, charge_short_comp, overload_comp};
    assign disable_vec = {discharge_short_sense_disable, charge_short_sense_disable, overload_sense_disable};

    // Latched trip releases once host drops both FET commands
    assign trip_clear = !charge_fet_bit && !discharge_fet_bit;

    pfd_timer_if tif[3] ();

    for (genvar i = 0; i < 3; i++) begin : g_chan
        assign tif[i].tick = wd_tick;
        assign tif[i].fault = comp_vec[i] && !disable_vec[i];
        assign tif[i].clear = trip_clear;
        assign tif[i].limit = limit_vec[i];
        assign trip_vec[i] = tif[i].trip;
        pfd_delay_timer u_timer (
            .clk(clk),
            .reset_n(reset_n),
            .bus(tif[i])
        );
    end

    assign overload_trip = trip_vec[PFD_CH_OL];
    assign charge_short_trip = trip_vec[PFD_CH_CHARGE_SHORT];
    assign discharge_short_trip = trip_vec[PFD_CH_DISCHARGE_SHORT];
    assign any_trip = |trip_vec;

    // FET drive selection
    always_comb begin
        next_charge_fet_drive = 1'b0;
        next_discharge_fet_drive = 1'b0;
        next_zero_volt_fet_drive = 1'b0;
        if (any_trip) begin
            next_charge_fet_drive = 1'b0;
        end else if (!supply_ok) begin
            next_charge_fet_drive = power_mode_select_input;
            next_zero_volt_fet_drive = !power_mode_select_input;
        end else begin
            next_charge_fet_drive = charge_fet_bit;
            next_discharge_fet_drive = discharge_fet_bit;
            next_zero_volt_fet_drive = !power_mode_select_input && !zero_volt_fet_off_bit;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            charge_fet_drive <= 1'b0;
            discharge_fet_drive <= 1'b0;
            zero_volt_fet_drive <= 1'b0;
        end else begin
            charge_fet_drive <= next_charge_fet_drive;
            discharge_fet_drive <= next_discharge_fet_drive;
            zero_volt_fet_drive <= next_zero_volt_fet_drive;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_OL_UPPER_ZERO: assert property (overload_delay[`PFD_DELAY_MSB:`PFD_DELAY_LSB] == 4'h0)
        else $error("overload delay upper nibble not zero");
    AST_OL_LIMIT: assert property (
        ##1 limit_vec[PFD_CH_OL] == pfd_ticks_t'(33 + 66 * $past(overload_delay_code)) ||
        $changed(overload_delay))
        else $error("overload delay limit wrong");
    AST_CHARGE_WRITE: assert property (reg_wr && reg_addr == `PFD_ADDR_CHARGE_SHORT |=>
        charge_short_level_code == $past(reg_wdata[3:0]) && charge_short_delay_code == $past(reg_wdata[7:4]))
        else $error("charge short fields not stored");
    AST_DISCHARGE_WRITE: assert property (reg_wr && reg_addr == `PFD_ADDR_DISCHARGE_SHORT |=>
        discharge_short_level_code == $past(reg_wdata[3:0]) &&
        discharge_short_delay_code == $past(reg_wdata[7:4]))
        else $error("discharge short fields not stored");
    AST_CHARGE_LIMIT: assert property (
        limit_vec[PFD_CH_CHARGE_SHORT] == {7'h00, charge_short_delay_code, 1'b0})
        else $error("charge short delay limit wrong");
    AST_DISCHARGE_LIMIT: assert property (
        limit_vec[PFD_CH_DISCHARGE_SHORT] == {7'h00, discharge_short_delay_code, 1'b0})
        else $error("discharge short delay limit wrong");
    AST_CHARGE_OFF: assert property (charge_short_trip |=>
        !charge_fet_drive && !discharge_fet_drive && !zero_volt_fet_drive)
        else $error("charge short trip left a drive on");
    AST_DISCHARGE_OFF: assert property (discharge_short_trip |=>
        !charge_fet_drive && !discharge_fet_drive && !zero_volt_fet_drive)
        else $error("discharge short trip left a drive on");
    AST_ZV_POWERUP: assert property (!power_mode_select_input && !supply_ok && !any_trip |=>
        !charge_fet_drive && zero_volt_fet_drive)
        else $error("zero-volt power-up drive state wrong");
    AST_COMMON_FORCE: assert property (power_mode_select_input && !supply_ok && !any_trip |=>
        charge_fet_drive)
        else $error("common mode charge drive not forced on");
    AST_SUPPLY_FOLLOW: assert property (supply_ok && !any_trip |=>
        charge_fet_drive == $past(charge_fet_bit))
        else $error("charge drive not following control bit");
    AST_DISABLE: assert property ($rose(overload_trip) |-> !$past(overload_sense_disable))
        else $error("overload trip while sensing disabled");
    AST_ZV_BIT: assert property (supply_ok && !power_mode_select_input && !any_trip |=>
        zero_volt_fet_drive == !$past(zero_volt_fet_off_bit))
        else $error("zero-volt drive not following off bit");
endmodule
`default_nettype wire

/* File: hdl/pfd_pkg.sv */
// Types shared by the fault delay block
`default_nettype none
package pfd_pkg;
    typedef logic [7:0] pfd_byte_t;
    typedef logic [3:0] pfd_code_t;
    typedef logic [11:0] pfd_ticks_t;
    typedef enum logic [1:0] {PFD_CH_OL, PFD_CH_CHARGE_SHORT, PFD_CH_DISCHARGE_SHORT} pfd_chan_t;
endpackage
`default_nettype wire

/* File: hdl/pfd_regs.svh */
// Register map, field layout and delay timing constants of the fault delay block
`ifndef PFD_REGS_SVH
`define PFD_REGS_SVH

`define PFD_ADDR_OVERLOAD_DELAY 8'h06
`define PFD_ADDR_CHARGE_SHORT 8'h07
`define PFD_ADDR_DISCHARGE_SHORT 8'h08

`define PFD_RST_OVERLOAD_DELAY 8'h00
`define PFD_RST_CHARGE_SHORT 8'h00
`define PFD_RST_DISCHARGE_SHORT 8'h00
`define PFD_RDATA_UNMAPPED 8'h00

`define PFD_OL_WRITE_MASK 8'h0f
`define PFD_LEVEL_MSB 3
`define PFD_LEVEL_LSB 0
`define PFD_DELAY_MSB 7
`define PFD_DELAY_LSB 4

`define PFD_WATCHDOG_FREQ_HZ 32768
`define PFD_OL_BASE_US 1000
`define PFD_OL_STEP_US 2000
`define PFD_SC_STEP_US 61
`define PFD_US_TO_TICKS(us) (((us) * `PFD_WATCHDOG_FREQ_HZ + 999999) / 1000000)
`define PFD_OL_BASE_TICKS `PFD_US_TO_TICKS(`PFD_OL_BASE_US)
`define PFD_OL_STEP_TICKS `PFD_US_TO_TICKS(`PFD_OL_STEP_US)
`define PFD_SC_STEP_TICKS `PFD_US_TO_TICKS(`PFD_SC_STEP_US)

`endif

/* File: hdl/pfd_timer_if.sv */
// Signals between the protection core and one fault delay timer
`default_nettype none
interface pfd_timer_if;
    import pfd_pkg::*;
    logic tick;
    logic fault;
    logic clear;
    pfd_ticks_t limit;
    logic trip;
    modport ctrl (output tick, output fault, output clear, output limit, input trip);
    modport timer (input tick, input fault, input clear, input limit, output trip);
endinterface
`default_nettype wire
